// [relay_self_test_supervisor.sv]
// Operation
// - On internal error, reboot; healthy off, watchdog operated
// - Log a maintenance record for every problem
// - Boot diagnostics, then continuous in-service checking
// - No protection or healthy until start-up passes
// - Start-up failure stays out until manual restore
// - Checksum flash before copying code to SRAM
// - Compare SRAM to flash before initialization entry
// - Init checks battery, records, field, display, watchdog
// - Platform checks data store, clock, time-code board
// - Last: input board, analog reference, then service
// - Periodic flash, compare, SRAM, battery, field checks
// - Each acquisition checks digital I/O and reference
// - Check time-code board on each time read
// - Silent Ethernet board: alarm and reset it
// - Battery or time-code faults keep running; others reboot
// - Restart outage bounded by five seconds
// - Same fault after restart: permanently out of service; checked at start-up only, so CK_SRAM_SUM and CK_DIO repeats reboot again
`include "relay_sup_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module relay_self_test_supervisor #(
  parameter int OUTAGE_CYC = `OUTAGE_CYC,
  parameter int SVC_PERIOD_CYC = `SVC_PERIOD_CYC,
  parameter int CHK_TIMEOUT_CYC = `CHK_TIMEOUT_CYC
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  input wire logic i_TC_FITTED,
  input wire logic i_ETH_FITTED,
  input wire logic i_ACQ_EXEC,
  input wire logic i_TC_READ,
  input wire logic i_ETH_NORESP,
  input wire logic i_CHK_DONE,
  input wire logic i_CHK_PASS,
  input wire logic i_MANUAL_RESTORE,
  output relay_sup_pkg::chk_req_type o_CHK,
  output relay_sup_pkg::log_rec_type o_LOG,
  output logic o_PROT_EN,
  output logic o_HEALTHY,
  output logic o_WDOG_CONTACT,
  output logic o_SYS_RESTART,
  output logic o_ETH_ALARM,
  output logic o_ETH_RESET,
  output logic o_PERMANENT
);
  import relay_sup_pkg::*;

  localparam int OW = $clog2(OUTAGE_CYC + 1);
  localparam int PW = $clog2(SVC_PERIOD_CYC + 1);
  localparam logic [OW-1:0] OUT_LAST = OW'(OUTAGE_CYC - 1);
  localparam logic [PW-1:0] PER_LAST = PW'(SVC_PERIOD_CYC - 1);

  // ********************************************************************
  // Sequencing helpers
  // ********************************************************************
  // Start-up order; the time-code check is skipped when no board is fitted
  function automatic check_type startup_next(input check_type c, input logic tc);
    check_type n;
    n = CK_NONE;
    case (c)
      CK_FLASH_SUM: n = CK_COPY;
      CK_COPY: n = CK_COPY_CMP;
      CK_COPY_CMP: n = CK_INIT;
      CK_INIT: n = CK_BATTERY;
      CK_BATTERY: n = CK_REC_MEM;
      CK_REC_MEM: n = CK_FIELD;
      CK_FIELD: n = CK_DISPLAY;
      CK_DISPLAY: n = CK_WDOG;
      CK_WDOG: n = CK_NV_SUM;
      CK_NV_SUM: n = CK_RTC;
      CK_RTC: n = tc ? CK_TIMECODE : CK_INPUT_BOARD;
      CK_TIMECODE: n = CK_INPUT_BOARD;
      CK_INPUT_BOARD: n = CK_ANALOG_REF;
      default: n = CK_NONE;
    endcase
    return n;
  endfunction

  // In-service follow-on; none ends the round
  function automatic check_type service_next(input check_type c);
    check_type n;
    n = CK_NONE;
    case (c)
      CK_FLASH_SUM: n = CK_COPY_CMP;
      CK_COPY_CMP: n = CK_SRAM_SUM;
      CK_SRAM_SUM: n = CK_BATTERY;
      CK_BATTERY: n = CK_FIELD;
      CK_DIO: n = CK_ANALOG_REF;
      default: n = CK_NONE;
    endcase
    return n;
  endfunction

  // ********************************************************************
  // State
  // ********************************************************************
  state_type state_r, state_nxt; // Supervisor state
  check_type cur_r, cur_nxt; // Check in progress
  check_type cause_r, cause_nxt; // Fault that forced the last restart
  logic [OW-1:0] out_cnt_r, out_cnt_nxt; // Outage time since restart
  logic [PW-1:0] per_cnt_r, per_cnt_nxt; // In-service round divider
  logic due_r, due_nxt; // Periodic round pending
  logic acq_pend_r, acq_pend_nxt; // Acquisition check pending
  logic tc_pend_r, tc_pend_nxt; // Time-code read check pending
  logic eth_log_r, eth_log_nxt; // Ethernet record waiting for the log port
  log_rec_type log_r, log_nxt; // Maintenance record strobe
  logic prot_r, prot_nxt; // Protection enable
  logic restart_r, restart_nxt; // Reboot strobe to the processor
  logic eth_alarm_r, eth_alarm_nxt; // Ethernet alarm
  logic eth_rst_r, eth_rst_nxt; // Ethernet board reset strobe
  logic perm_r, perm_nxt; // Permanently out of service

  // Check unit handshake
  logic start; // Start a check this cycle
  check_type start_code; // Which check to start
  logic res_valid; // Result strobe
  logic res_pass; // Result value

  // ********************************************************************
  // Check unit
  // ********************************************************************
  relay_check_unit #(
    .TIMEOUT_CYC(CHK_TIMEOUT_CYC)
  ) u_check (
    .i_clk(I_SYS_CLK),
    .i_resetn(I_RESETN),
    .i_start(start),
    .i_code(start_code),
    .i_done(i_CHK_DONE),
    .i_pass(i_CHK_PASS),
    .o_req(o_CHK),
    .o_res_valid(res_valid),
    .o_res_pass(res_pass)
  );

  // ********************************************************************
  // Supervisor next values
  // ********************************************************************
  always_comb begin
    check_type nx;
    nx = CK_NONE;
    state_nxt = state_r;
    cur_nxt = cur_r;
    cause_nxt = cause_r;
    out_cnt_nxt = out_cnt_r;
    per_cnt_nxt = per_cnt_r;
    due_nxt = due_r;
    acq_pend_nxt = acq_pend_r;
    tc_pend_nxt = tc_pend_r;
    eth_log_nxt = eth_log_r;
    log_nxt = '{valid: 1'b0, code: CK_NONE, in_service: 1'b0, fatal: 1'b0};
    restart_nxt = 1'b0;
    eth_alarm_nxt = eth_alarm_r;
    eth_rst_nxt = 1'b0;
    start = 1'b0;
    start_code = CK_NONE;

    case (state_r)
      // Begin the boot diagnostics with the flash checksum
      ST_RESTART: begin
        start = 1'b1;
        start_code = CK_FLASH_SUM;
        cur_nxt = CK_FLASH_SUM;
        out_cnt_nxt = '0;
        eth_alarm_nxt = 1'b0;
        state_nxt = ST_START_WAIT;
      end

      // Start-up sequence; protection stays off throughout
      ST_START_WAIT: begin
        if (out_cnt_r != OUT_LAST) begin
          out_cnt_nxt = out_cnt_r + 1'b1;
        end
        if (cause_r != CK_NONE && out_cnt_r == OUT_LAST) begin
          // Restart has run too long; give up rather than overrun the outage
          log_nxt = '{valid: 1'b1, code: CK_OUTAGE, in_service: 1'b0, fatal: 1'b1};
          state_nxt = ST_HALT;
        end else if (res_valid && res_pass) begin
          nx = startup_next(cur_r, i_TC_FITTED);
          if (nx == CK_NONE) begin
            // All start-up tests passed: enter service
            cause_nxt = CK_NONE;
            per_cnt_nxt = '0;
            due_nxt = 1'b0;
            acq_pend_nxt = 1'b0;
            tc_pend_nxt = 1'b0;
            state_nxt = ST_RUN;
          end else begin
            start = 1'b1;
            start_code = nx;
            cur_nxt = nx;
          end
        end else if (res_valid) begin
          // Start-up failure never leads into service on its own
          log_nxt = '{valid: 1'b1, code: cur_r, in_service: 1'b0, fatal: 1'b1};
          if (cur_r == cause_r) begin
            state_nxt = ST_PERM;
          end else begin
            state_nxt = ST_HALT;
          end
        end
      end

      // In service and idle: pick the next pending check
      ST_RUN: begin
        if (acq_pend_r) begin
          start = 1'b1;
          start_code = CK_DIO;
          cur_nxt = CK_DIO;
          acq_pend_nxt = 1'b0;
          state_nxt = ST_RUN_WAIT;
        end else if (tc_pend_r) begin
          start = 1'b1;
          start_code = CK_TIMECODE;
          cur_nxt = CK_TIMECODE;
          tc_pend_nxt = 1'b0;
          state_nxt = ST_RUN_WAIT;
        end else if (due_r) begin
          start = 1'b1;
          start_code = CK_FLASH_SUM;
          cur_nxt = CK_FLASH_SUM;
          due_nxt = 1'b0;
          state_nxt = ST_RUN_WAIT;
        end
      end

      // In service, a check is running
      ST_RUN_WAIT: begin
        if (res_valid) begin
          if (!res_pass) begin
            log_nxt = '{valid: 1'b1, code: cur_r, in_service: 1'b1, fatal: 1'b0};
          end
          if (!res_pass && cur_r != CK_BATTERY && cur_r != CK_TIMECODE) begin
            // Fatal area: remember the cause and reboot
            log_nxt.fatal = 1'b1;
            cause_nxt = cur_r;
            restart_nxt = 1'b1;
            state_nxt = ST_RESTART;
          end else begin
            // Pass, or a fault that leaves the relay running
            nx = service_next(cur_r);
            if (nx == CK_NONE) begin
              state_nxt = ST_RUN;
            end else begin
              start = 1'b1;
              start_code = nx;
              cur_nxt = nx;
            end
          end
        end
      end

      // Out of service until an operator restores it
      ST_HALT: begin
        if (i_MANUAL_RESTORE) begin
          cause_nxt = CK_NONE;
          restart_nxt = 1'b1;
          state_nxt = ST_RESTART;
        end
      end

      // Permanently out; only a power-on reset leaves this state
      ST_PERM: begin
        state_nxt = ST_PERM;
      end

      default: begin
        state_nxt = ST_RESTART;
      end
    endcase

    // In-service timers and event captures; an event in the taking cycle wins
    if (state_r == ST_RUN || state_r == ST_RUN_WAIT) begin
      if (per_cnt_r == PER_LAST) begin
        per_cnt_nxt = '0;
        due_nxt = 1'b1;
      end else begin
        per_cnt_nxt = per_cnt_r + 1'b1;
      end
      if (i_ACQ_EXEC) begin
        acq_pend_nxt = 1'b1;
      end
      if (i_TC_READ && i_TC_FITTED) begin
        tc_pend_nxt = 1'b1;
      end
      if (i_ETH_NORESP && i_ETH_FITTED) begin
        eth_alarm_nxt = 1'b1;
        eth_rst_nxt = 1'b1;
        eth_log_nxt = 1'b1;
      end
    end

    // Ethernet record waits for a cycle with no other record
    if (eth_log_r && !log_nxt.valid) begin
      log_nxt = '{valid: 1'b1, code: CK_ETH, in_service: 1'b1, fatal: 1'b0};
      eth_log_nxt = i_ETH_NORESP && i_ETH_FITTED && prot_r;
    end

    // Indicator and contact follow the next state so they match it exactly
    prot_nxt = (state_nxt == ST_RUN) || (state_nxt == ST_RUN_WAIT);
    perm_nxt = (state_nxt == ST_PERM);
  end

  // ********************************************************************
  // Supervisor registers
  // ********************************************************************
  // Power-on reset is a fresh boot with no remembered cause
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      state_r <= ST_RESTART;
      cur_r <= CK_NONE;
      cause_r <= CK_NONE;
      out_cnt_r <= '0;
      per_cnt_r <= '0;
      due_r <= 1'b0;
      acq_pend_r <= 1'b0;
      tc_pend_r <= 1'b0;
      eth_log_r <= 1'b0;
      log_r <= '{valid: 1'b0, code: CK_NONE, in_service: 1'b0, fatal: 1'b0};
      prot_r <= 1'b0;
      restart_r <= 1'b0;
      eth_alarm_r <= 1'b0;
      eth_rst_r <= 1'b0;
      perm_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      cause_r <= cause_nxt;
      out_cnt_r <= out_cnt_nxt;
      per_cnt_r <= per_cnt_nxt;
      due_r <= due_nxt;
      acq_pend_r <= acq_pend_nxt;
      tc_pend_r <= tc_pend_nxt;
      eth_log_r <= eth_log_nxt;
      log_r <= log_nxt;
      prot_r <= prot_nxt;
      restart_r <= restart_nxt;
      eth_alarm_r <= eth_alarm_nxt;
      eth_rst_r <= eth_rst_nxt;
      perm_r <= perm_nxt;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  // Healthy lit and contact released only while protection runs
  assign o_LOG = log_r;
  assign o_PROT_EN = prot_r;
  assign o_HEALTHY = prot_r;
  assign o_WDOG_CONTACT = ~prot_r;
  assign o_SYS_RESTART = restart_r;
  assign o_ETH_ALARM = eth_alarm_r;
  assign o_ETH_RESET = eth_rst_r;
  assign o_PERMANENT = perm_r;

endmodule

`default_nettype wire

// [relay_sup_defs.svh]
`ifndef RELAY_SUP_DEFS_SVH
`define RELAY_SUP_DEFS_SVH

// ********************************************************************
// Clock and timing figures
// ********************************************************************
// System clock rate in hertz
`define CLK_FREQ_HZ 25000000
// Clock cycles in one millisecond
`define CLK_PER_MS (`CLK_FREQ_HZ / 1000)
// Longest protection outage after a fault restart, in milliseconds
`define OUTAGE_MAX_MS 5000
// Interval between in-service check rounds, in milliseconds
`define SVC_PERIOD_MS 1000
// Longest wait for a subsystem to answer one check, in milliseconds
`define CHK_TIMEOUT_MS 10

// ********************************************************************
// Derived cycle counts
// ********************************************************************
// Longest time rounds down to whole cycles
`define OUTAGE_CYC (`OUTAGE_MAX_MS * `CLK_PER_MS)
`define SVC_PERIOD_CYC (`SVC_PERIOD_MS * `CLK_PER_MS)
`define CHK_TIMEOUT_CYC (`CHK_TIMEOUT_MS * `CLK_PER_MS)

`endif

// [relay_sup_pkg.sv]
// ********************************************************************
// Types shared by the supervisor and its check unit
// ********************************************************************
package relay_sup_pkg;

  // Check areas, in start-up order first, then in-service only areas, then the start-up outage record code
  typedef enum logic [4:0] {
    CK_NONE,
    CK_FLASH_SUM,
    CK_COPY,
    CK_COPY_CMP,
    CK_INIT,
    CK_BATTERY,
    CK_REC_MEM,
    CK_FIELD,
    CK_DISPLAY,
    CK_WDOG,
    CK_NV_SUM,
    CK_RTC,
    CK_TIMECODE,
    CK_INPUT_BOARD,
    CK_ANALOG_REF,
    CK_SRAM_SUM,
    CK_DIO,
    CK_ETH,
    CK_OUTAGE
  } check_type;

  // Request to a processor subsystem to run one check
  typedef struct packed {
    logic req;
    check_type code;
  } chk_req_type;

  // Maintenance record toward battery-backed memory
  typedef struct packed {
    logic valid;
    check_type code;
    logic in_service;
    logic fatal;
  } log_rec_type;

  // Supervisor states
  typedef enum logic [2:0] {
    ST_RESTART,
    ST_START_WAIT,
    ST_RUN,
    ST_RUN_WAIT,
    ST_HALT,
    ST_PERM
  } state_type;

endpackage

// [relay_check_unit.sv]
`timescale 1ns/1ps
`default_nettype none

// ********************************************************************
// One outstanding check: holds the request until the subsystem answers
// or the wait runs out, then reports pass or fail for one cycle
// ********************************************************************
module relay_check_unit #(
  parameter int TIMEOUT_CYC = 250000
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire relay_sup_pkg::check_type i_code,
  input wire logic i_done,
  input wire logic i_pass,
  output relay_sup_pkg::chk_req_type o_req,
  output logic o_res_valid,
  output logic o_res_pass
);
  import relay_sup_pkg::*;

  localparam int CW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYC - 1);

  chk_req_type req_r, req_nxt; // Request shown to the subsystem
  logic [CW-1:0] cnt_r, cnt_nxt; // Cycles spent waiting
  logic val_r, val_nxt; // Result strobe
  logic pass_r, pass_nxt; // Result value

  // ********************************************************************
  // Next values
  // ********************************************************************
  // A silent subsystem counts as failed, so a hung part cannot stall start-up
  always_comb begin
    req_nxt = req_r;
    cnt_nxt = cnt_r;
    val_nxt = 1'b0;
    pass_nxt = 1'b0;
    if (i_start) begin
      // New check replaces anything still in flight
      req_nxt.req = 1'b1;
      req_nxt.code = i_code;
      cnt_nxt = '0;
    end else if (req_r.req) begin
      if (i_done) begin
        // Subsystem answered
        req_nxt.req = 1'b0;
        val_nxt = 1'b1;
        pass_nxt = i_pass;
      end else if (cnt_r == LAST) begin
        // Wait ran out
        req_nxt.req = 1'b0;
        val_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      req_r <= '{req: 1'b0, code: CK_NONE};
      cnt_r <= '0;
      val_r <= 1'b0;
      pass_r <= 1'b0;
    end else begin
      req_r <= req_nxt;
      cnt_r <= cnt_nxt;
      val_r <= val_nxt;
      pass_r <= pass_nxt;
    end
  end

  assign o_req = req_r;
  assign o_res_valid = val_r;
  assign o_res_pass = pass_r;

endmodule

`default_nettype wire

// [relay_sup_properties.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Port checker for the self-test supervisor
// ****************************************
module relay_sup_properties #(
  parameter int OUTAGE_CYC = 200
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  input wire logic i_ETH_FITTED,
  input wire logic i_ETH_NORESP,
  input wire logic i_CHK_DONE,
  input wire logic i_CHK_PASS,
  input wire relay_sup_pkg::chk_req_type o_CHK,
  input wire relay_sup_pkg::log_rec_type o_LOG,
  input wire logic o_PROT_EN,
  input wire logic o_HEALTHY,
  input wire logic o_WDOG_CONTACT,
  input wire logic o_SYS_RESTART,
  input wire logic o_ETH_ALARM,
  input wire logic o_ETH_RESET,
  input wire logic o_PERMANENT
);
  import relay_sup_pkg::*;
  // Slack covers the result strobe and log cycles after the timer runs out
  localparam int OUT_LIM = OUTAGE_CYC + 4;
  check_type last_code_r; // Last answered check
  check_type last_code_nxt;
  logic last_pass_r; // Its verdict
  logic last_pass_nxt;

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);

  // Remember each answer so service entry can be tied to its cause
  always_comb begin
    last_code_nxt = last_code_r;
    last_pass_nxt = last_pass_r;
    if (i_CHK_DONE && o_CHK.req) begin
      last_code_nxt = o_CHK.code;
      last_pass_nxt = i_CHK_PASS;
    end
  end

  // Plain register stage
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      last_code_r <= CK_NONE;
      last_pass_r <= 1'b0;
    end else begin
      last_code_r <= last_code_nxt;
      last_pass_r <= last_pass_nxt;
    end
  end

  AST_HEALTHY_IS_PROT: assert property (o_HEALTHY == o_PROT_EN)
    else $error("healthy lamp differs from protection enable");
  AST_WDOG_OUT: assert property (o_WDOG_CONTACT == !o_PROT_EN)
    else $error("watchdog contact not opposite to protection");
  AST_RESTART_DROPS: assert property (o_SYS_RESTART |-> !o_PROT_EN ##1 !o_SYS_RESTART)
    else $error("restart strobe with protection on or too long");
  AST_PERM_HOLDS: assert property (o_PERMANENT |=> o_PERMANENT && !o_PROT_EN)
    else $error("left permanent out of service");
  AST_FATAL_REBOOT: assert property (o_LOG.valid && o_LOG.fatal && o_LOG.in_service && o_LOG.code != CK_OUTAGE |-> o_SYS_RESTART)
    else $error("fatal service fault without reboot");
  AST_MINOR_CODES: assert property (o_LOG.valid && !o_LOG.fatal |-> o_LOG.code inside {CK_BATTERY, CK_TIMECODE, CK_ETH})
    else $error("non-fatal record for a fatal area");
  AST_ENTRY_LAST: assert property ($rose(o_PROT_EN) |-> last_code_r == CK_ANALOG_REF && last_pass_r)
    else $error("service entered without final reference pass");
  AST_CODE_STEADY: assert property (o_CHK.req && $past(o_CHK.req) |-> $stable(o_CHK.code))
    else $error("check code changed while requested");
  AST_OUTAGE_BOUND: assert property (o_SYS_RESTART |-> ##[1:OUT_LIM] (o_PROT_EN || o_LOG.valid))
    else $error("restart outage exceeded");
  AST_ETH_RECOVER: assert property (i_ETH_NORESP && i_ETH_FITTED && o_PROT_EN |=> o_ETH_ALARM && o_ETH_RESET)
    else $error("silent network board not alarmed and reset");
endmodule

bind relay_self_test_supervisor relay_sup_properties #(.OUTAGE_CYC(OUTAGE_CYC)) i_props (
  .I_SYS_CLK(I_SYS_CLK), .I_RESETN(I_RESETN), .i_ETH_FITTED(i_ETH_FITTED),
  .i_ETH_NORESP(i_ETH_NORESP), .i_CHK_DONE(i_CHK_DONE), .i_CHK_PASS(i_CHK_PASS),
  .o_CHK(o_CHK), .o_LOG(o_LOG), .o_PROT_EN(o_PROT_EN), .o_HEALTHY(o_HEALTHY),
  .o_WDOG_CONTACT(o_WDOG_CONTACT), .o_SYS_RESTART(o_SYS_RESTART),
  .o_ETH_ALARM(o_ETH_ALARM), .o_ETH_RESET(o_ETH_RESET), .o_PERMANENT(o_PERMANENT)
);

`default_nettype wire

// [relay_proc_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Processor subsystems answering each check
// ****************************************
module relay_proc_model (
  input wire logic i_clk,
  input wire relay_sup_pkg::chk_req_type i_chk,
  output logic o_done,
  output logic o_pass
);
  import relay_sup_pkg::*;
  check_type fail_code = CK_NONE; // Area that reports a fault
  int fail_left = 0; // Faults still to report there
  int dly = 0; // Extra cycles before each answer
  check_type seen[$]; // Codes answered, in order

  // One answer per request, driven just after the edge
  initial begin
    o_done = 1'b0;
    o_pass = 1'b0;
    forever begin
      @(posedge i_clk);
      #2;
      if (i_chk.req === 1'b1) begin
        for (int k = 0; k < dly; k++) begin
          @(posedge i_clk);
          #2;
        end
        seen.push_back(i_chk.code);
        o_pass = !(i_chk.code == fail_code && fail_left > 0);
        o_done = 1'b1;
        if (!o_pass) fail_left--;
        @(posedge i_clk);
        #2;
        o_done = 1'b0;
        // Stale verdict is inverted so it never looks valid by luck
        o_pass = ~o_pass;
        while (i_chk.req === 1'b1) begin
          @(posedge i_clk);
          #2;
        end
      end
    end
  end
endmodule

`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import relay_sup_pkg::*;
  logic clk, rstn, tc_fit, eth_fit, acq, tc_rd, eth_nr, restore, done, pass;
  chk_req_type chk;
  log_rec_type log_rec;
  logic prot, healthy, wdog, restart, eth_alarm, eth_rst, perm;
  int error_cnt = 0;
  int comparisons = 0;
  int restart_n = 0; // Reboot strobes seen
  int ethrst_n = 0; // Network board resets seen
  log_rec_type log_q[$]; // Maintenance records seen

  relay_self_test_supervisor #(.OUTAGE_CYC(200), .SVC_PERIOD_CYC(100),
    .CHK_TIMEOUT_CYC(20)) i_dut (
    .I_SYS_CLK(clk), .I_RESETN(rstn), .i_TC_FITTED(tc_fit), .i_ETH_FITTED(eth_fit),
    .i_ACQ_EXEC(acq), .i_TC_READ(tc_rd), .i_ETH_NORESP(eth_nr), .i_CHK_DONE(done),
    .i_CHK_PASS(pass), .i_MANUAL_RESTORE(restore), .o_CHK(chk), .o_LOG(log_rec),
    .o_PROT_EN(prot), .o_HEALTHY(healthy), .o_WDOG_CONTACT(wdog),
    .o_SYS_RESTART(restart), .o_ETH_ALARM(eth_alarm), .o_ETH_RESET(eth_rst),
    .o_PERMANENT(perm));

  relay_proc_model i_model (.i_clk(clk), .i_chk(chk), .o_done(done), .o_pass(pass));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Collect strobes; each one-cycle pulse is counted once
  always @(posedge clk) begin
    if (log_rec.valid === 1'b1) log_q.push_back(log_rec);
    if (restart === 1'b1) restart_n++;
    if (eth_rst === 1'b1) ethrst_n++;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // Bounded wait for protection to reach a level; n returns cycles spent
  task automatic wait_prot(input logic v, output int n);
    n = 0;
    while (prot !== v && n < 400) begin
      cyc(1);
      n++;
    end
  endtask

  // Reset held 5 cycles; model's answered-code list, records and reboot count cleared as it is applied
  task automatic boot(input logic tc);
    tc_fit = tc;
    rstn = 1'b0;
    i_model.seen.delete();
    log_q.delete();
    restart_n = 0;
    cyc(5);
    rstn = 1'b1;
  endtask

  function automatic logic has_run(input check_type want[$]);
    logic ok;
    has_run = 1'b0;
    for (int s = 0; s + want.size() <= i_model.seen.size(); s++) begin
      ok = 1'b1;
      foreach (want[k]) if (i_model.seen[s + k] != want[k]) ok = 1'b0;
      if (ok) has_run = 1'b1;
    end
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_boot;
    int n;
    check_type exp[$];
    for (int tc = 0; tc < 2; tc++) begin
      i_model.dly = 2 * tc; // Second pass answers slowly
      boot(tc[0]);
      exp.delete();
      for (int c = 1; c <= 14; c++) if (c != 12 || tc == 1) exp.push_back(check_type'(c));
      cyc(6);
      check({prot, healthy, wdog}, 3'h1);
      wait_prot(1'b1, n);
      check(i_model.seen.size(), exp.size());
      foreach (exp[k]) check(i_model.seen[k], exp[k]);
      check({prot, healthy, wdog}, 3'h6);
    end
    i_model.dly = 0;
    $display("test boot finished");
  endtask

  task automatic t_service;
    i_model.seen.delete();
    acq = 1'b1;
    cyc(1);
    acq = 1'b0;
    cyc(20);
    check(has_run('{CK_DIO, CK_ANALOG_REF}), 1);
    i_model.seen.delete();
    tc_rd = 1'b1;
    cyc(1);
    tc_rd = 1'b0;
    cyc(20);
    check(has_run('{CK_TIMECODE}), 1);
    i_model.seen.delete();
    cyc(130);
    check(has_run('{CK_FLASH_SUM, CK_COPY_CMP, CK_SRAM_SUM, CK_BATTERY, CK_FIELD}), 1);
    $display("test service finished");
  endtask

  task automatic t_minor;
    check_type codes[2] = '{CK_BATTERY, CK_TIMECODE};
    foreach (codes[k]) begin
      log_q.delete();
      i_model.fail_code = codes[k];
      i_model.fail_left = 1;
      tc_rd = (codes[k] == CK_TIMECODE);
      cyc(1);
      tc_rd = 1'b0;
      cyc(130);
      check(log_q.size(), 1);
      check(log_q[0], {1'b1, codes[k], 1'b1, 1'b0});
      check({prot, restart_n[0]}, 2'h2);
    end
    $display("test minor finished");
  endtask

  task automatic t_eth;
    log_q.delete();
    eth_fit = 1'b1;
    eth_nr = 1'b1;
    cyc(1);
    eth_nr = 1'b0;
    cyc(10);
    check({eth_alarm, prot, ethrst_n[1:0]}, 4'hD);
    check({log_q[0].code, log_q[0].fatal}, {CK_ETH, 1'b0});
    $display("test network finished");
  endtask

  // Fault in service; fails_left=2 repeats it at start-up
  task automatic t_fatal(input int fails);
    int n;
    i_model.fail_code = CK_FIELD;
    i_model.fail_left = fails;
    // Earlier scenarios leave records and strobe counts behind
    log_q.delete();
    restart_n = 0;
    wait_prot(1'b0, n);
    cyc(2);
    check(log_q[0], {1'b1, CK_FIELD, 1'b1, 1'b1});
    check({restart_n[1:0], healthy, wdog}, 4'h5);
    wait_prot(1'b1, n);
    if (fails == 1) begin
      check(n <= 200, 1);
    end else begin
      check({perm, prot, wdog}, 3'h5);
      check(log_q[1], {1'b1, CK_FIELD, 1'b0, 1'b1});
      restore = 1'b1;
      cyc(1);
      restore = 1'b0;
      cyc(60);
      check({perm, prot}, 2'h2);
    end
    $display("test fatal finished");
  endtask

  task automatic t_halt;
    int n;
    i_model.fail_code = CK_RTC;
    i_model.fail_left = 1;
    boot(1'b1);
    cyc(300);
    check({prot, perm, wdog}, 3'h1);
    check(log_q[0], {1'b1, CK_RTC, 1'b0, 1'b1});
    restore = 1'b1;
    cyc(1);
    restore = 1'b0;
    wait_prot(1'b1, n);
    check({prot, restart_n[1:0]}, 3'h5);
    $display("test halt finished");
  endtask

  task automatic close_out;
    $display("comparisons=%0d mismatches=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Whole run needs a few thousand cycles
  initial begin
    #800000;
    error_cnt++;
    close_out();
  end

  initial begin
    {rstn, tc_fit, eth_fit, acq, tc_rd, eth_nr, restore} = 7'h0;
    cyc(1);
    t_boot();
    t_service();
    t_minor();
    t_eth();
    t_fatal(1);
    t_fatal(2);
    t_halt();
    close_out();
  end
endmodule

`default_nettype wire
